// file: design/dfpc_prescale.v
// Per-channel step prescaler for the fan pulse generator.
// Assumes one system clock; emits one-cycle step enables.
`timescale 1ns/1ns

module dfpc_prescale #(
  parameter integer CW   = 16,
  parameter integer DIV0 = 32,
  parameter integer DIV1 = 16,
  parameter integer DIV2 = 8,
  parameter integer DIV3 = 4
) (
  // Clock and reset
  input  wire          clk_sys_i,
  input  wire          reset_i,
  // Select
  input  wire [1:0]    sel_i,
  input  wire          double_i,
  // Step enable
  output reg           step_o
);

  // ****************************************************************
  // Divider
  // ****************************************************************
  reg  [CW-1:0] cnt_q;
  reg  [CW-1:0] lim;

  always @* begin
    case (sel_i)
      2'h0:    lim = DIV0[CW-1:0];
      2'h1:    lim = DIV1[CW-1:0];
      2'h2:    lim = DIV2[CW-1:0];
      default: lim = DIV3[CW-1:0];
    endcase
    // Halving the step period doubles the output frequency
    if (double_i) begin
      lim = lim >> 1;
    end
    if (lim == {CW{1'b0}}) begin
      lim = {{(CW-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      cnt_q  <= {CW{1'b0}};
      step_o <= 1'b0;
    end else if (cnt_q >= lim - {{(CW-1){1'b0}}, 1'b1}) begin
      // Compare with >= so a shorter new period never overruns
      cnt_q  <= {CW{1'b0}};
      step_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
      step_o <= 1'b0;
    end
  end

endmodule // dfpc_prescale

// file: design/dfpc_top.v
// Two-channel fan drive: registers, duty generators and tachometer clock enables.
// Assumes a plain register port synchronous to clk_sys_i, 100 MHz.
// Functional notes
// - Static bit set drives the channel output continuously high, duty ignored.
// - Static bit clear modulates the output with the six-bit duty field.
// - Duty counts high steps out of 64; zero stays low, 63 leaves one low.
// - Drive bit 7 selects clock, combined with source and multiplier bits.
// - Control bit 0 is channel one source select, bit 1 channel two.
// - Control bits 2 and 3 double each channel's output frequency when set.
// - Control bits 5:4 and 7:6 divide tachometer clock by 1,2,4,8; default 2.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
`include "dfpc_map.vh"

module dfpc_top #(
  parameter integer CW      = 16,
  parameter integer STEP_00 = (`DFPC_STEP_T00_NS + `DFPC_CLK_PERIOD_NS - 1) / `DFPC_CLK_PERIOD_NS,
  parameter integer STEP_01 = (`DFPC_STEP_T01_NS + `DFPC_CLK_PERIOD_NS - 1) / `DFPC_CLK_PERIOD_NS,
  parameter integer STEP_10 = (`DFPC_STEP_T10_NS + `DFPC_CLK_PERIOD_NS - 1) / `DFPC_CLK_PERIOD_NS,
  parameter integer STEP_11 = (`DFPC_STEP_T11_NS + `DFPC_CLK_PERIOD_NS - 1) / `DFPC_CLK_PERIOD_NS,
  parameter integer TACH_BASE = (`DFPC_TACH_BASE_NS + `DFPC_CLK_PERIOD_NS - 1) /
                                `DFPC_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire          clk_sys_i,
  input  wire          reset_i,
  // Register port
  input  wire [7:0]    reg_addr_i,
  input  wire [7:0]    reg_wdata_i,
  input  wire          reg_wr_i,
  input  wire          reg_rd_i,
  output reg  [7:0]    reg_rdata_o,
  // Fan outputs
  output reg           drive_out_a_o,
  output reg           drive_out_b_o,
  // Tachometer counting enables
  output reg           tach_tick_a_o,
  output reg           tach_tick_b_o
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [7:0] fan_one_drive_q;
  reg  [7:0] fan_two_drive_q;
  reg  [7:0] fan_clocking_control_q;

  // Reset models the standby power-on reset of the register file
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      fan_one_drive_q        <= `DFPC_RST_FAN_DRIVE;
      fan_two_drive_q        <= `DFPC_RST_FAN_DRIVE;
      fan_clocking_control_q <= `DFPC_RST_FAN_CLOCKING;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `DFPC_OFS_FAN_ONE_DRIVE: fan_one_drive_q        <= reg_wdata_i;
        `DFPC_OFS_FAN_TWO_DRIVE: fan_two_drive_q        <= reg_wdata_i;
        `DFPC_OFS_FAN_CLOCKING:  fan_clocking_control_q <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Unmapped addresses read zero; data valid only in the cycle after the strobe
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `DFPC_OFS_FAN_ONE_DRIVE: reg_rdata_o <= fan_one_drive_q;
        `DFPC_OFS_FAN_TWO_DRIVE: reg_rdata_o <= fan_two_drive_q;
        `DFPC_OFS_FAN_CLOCKING:  reg_rdata_o <= fan_clocking_control_q;
        default:                 reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ****************************************************************
  // Channel fields
  // ****************************************************************
  wire [7:0] drv [0:1];
  wire [1:0] src;
  wire [1:0] mul;
  wire [3:0] tdiv;
  wire [1:0] step;
  wire [1:0] pwm;
  wire [1:0] tick;

  assign drv[0] = fan_one_drive_q;
  assign drv[1] = fan_two_drive_q;
  assign src[0] = fan_clocking_control_q[`DFPC_CTL_SRC_A_BIT];
  assign src[1] = fan_clocking_control_q[`DFPC_CTL_SRC_B_BIT];
  assign mul[0] = fan_clocking_control_q[`DFPC_CTL_MUL_A_BIT];
  assign mul[1] = fan_clocking_control_q[`DFPC_CTL_MUL_B_BIT];
  assign tdiv[1:0] = fan_clocking_control_q[`DFPC_CTL_DIV_A_MSB:`DFPC_CTL_DIV_A_LSB];
  assign tdiv[3:2] = fan_clocking_control_q[`DFPC_CTL_DIV_B_MSB:`DFPC_CTL_DIV_B_LSB];

  // ****************************************************************
  // Tachometer base divider, shared by both channels
  // ****************************************************************
  reg  [CW-1:0] tbase_q;
  reg           tbase_en_q;

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      tbase_q    <= {CW{1'b0}};
      tbase_en_q <= 1'b0;
    end else if (tbase_q == TACH_BASE[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
      tbase_q    <= {CW{1'b0}};
      tbase_en_q <= 1'b1;
    end else begin
      tbase_q    <= tbase_q + {{(CW-1){1'b0}}, 1'b1};
      tbase_en_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Per-channel pulse generator and tachometer divider
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ch
      reg  [5:0] phase_q;
      reg        out_q;
      reg  [2:0] tcnt_q;
      reg        tick_q;
      wire [5:0] duty = drv[g][`DFPC_DRV_DUTY_MSB:`DFPC_DRV_DUTY_LSB];
      wire [2:0] tmask;

      // Clock select and source select pick one of four base rates
      dfpc_prescale #(
        .CW   (CW),
        .DIV0 (STEP_00),
        .DIV1 (STEP_01),
        .DIV2 (STEP_10),
        .DIV3 (STEP_11)
      ) u_pre (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .sel_i     ({drv[g][`DFPC_DRV_CLKSEL_BIT], src[g]}),
        .double_i  (mul[g]),
        .step_o    (step[g])
      );

      // 64 steps per period: high while phase is below the duty code
      always @(posedge clk_sys_i) begin
        if (reset_i) begin
          phase_q <= 6'h00;
          out_q   <= 1'b0;
        end else begin
          if (step[g]) begin
            phase_q <= phase_q + 6'h01;
          end
          if (drv[g][`DFPC_DRV_STATIC_BIT]) begin
            out_q <= 1'b1;
          end else begin
            out_q <= (phase_q < duty);
          end
        end
      end

      // Divisor 1,2,4,8 from a 2-bit code
      assign tmask = (tdiv[2*g+1:2*g] == 2'h0) ? 3'h0 :
                     (tdiv[2*g+1:2*g] == 2'h1) ? 3'h1 :
                     (tdiv[2*g+1:2*g] == 2'h2) ? 3'h3 : 3'h7;

      always @(posedge clk_sys_i) begin
        if (reset_i) begin
          tcnt_q <= 3'h0;
          tick_q <= 1'b0;
        end else if (tbase_en_q) begin
          tcnt_q <= tcnt_q + 3'h1;
          tick_q <= ((tcnt_q & tmask) == tmask);
        end else begin
          tick_q <= 1'b0;
        end
      end

      assign pwm[g]  = out_q;
      assign tick[g] = tick_q;
    end
  endgenerate

  always @* begin
    drive_out_a_o = pwm[0];
    drive_out_b_o = pwm[1];
    tach_tick_a_o = tick[0];
    tach_tick_b_o = tick[1];
  end

endmodule // dfpc_top

// file: inc/dfpc_map.vh
// Register map, field positions, reset values and timing counts for the fan drive block.
// Assumes byte-wide registers reached at their printed offsets.
`ifndef DFPC_MAP_VH
`define DFPC_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define DFPC_OFS_FAN_ONE_DRIVE  8'h56
`define DFPC_OFS_FAN_TWO_DRIVE  8'h57
`define DFPC_OFS_FAN_CLOCKING   8'h58

// ****************************************************************
// Reset values
// ****************************************************************
`define DFPC_RST_FAN_DRIVE      8'h00
`define DFPC_RST_FAN_CLOCKING   8'h50

// ****************************************************************
// Field positions
// ****************************************************************
`define DFPC_DRV_STATIC_BIT     0
`define DFPC_DRV_DUTY_LSB       1
`define DFPC_DRV_DUTY_MSB       6
`define DFPC_DRV_CLKSEL_BIT     7
`define DFPC_CTL_SRC_A_BIT      0
`define DFPC_CTL_SRC_B_BIT      1
`define DFPC_CTL_MUL_A_BIT      2
`define DFPC_CTL_MUL_B_BIT      3
`define DFPC_CTL_DIV_A_LSB      4
`define DFPC_CTL_DIV_A_MSB      5
`define DFPC_CTL_DIV_B_LSB      6
`define DFPC_CTL_DIV_B_MSB      7

// ****************************************************************
// Timing: base step periods in ns, converted to 100 MHz cycles
// ****************************************************************
`define DFPC_CLK_PERIOD_NS      10
`define DFPC_STEP_T00_NS        320
`define DFPC_STEP_T01_NS        160
`define DFPC_STEP_T10_NS        80
`define DFPC_STEP_T11_NS        40
`define DFPC_TACH_BASE_NS       1000

`endif

// file: sim/dfpc_fan_model.sv
// Fan drive input model: measures the last high and low run on one line.
// Assumes the line is a flop output on clk_sys_i.
`timescale 1ns/1ns
module dfpc_fan_model (
  // Clock and sensed line
  input  wire        clk_sys_i,
  input  wire        line_i,
  // Last run lengths in cycles
  output reg  [15:0] hi_len_o = 16'h0,
  output reg  [15:0] lo_len_o = 16'h0
);
  reg [15:0] run_q  = 16'h0;
  reg        last_q = 1'b0;
  // The motor input only senses the line, so nothing is driven back
  always @(posedge clk_sys_i) begin
    if (line_i !== last_q) begin
      if (last_q) hi_len_o <= run_q;
      else lo_len_o <= run_q;
      run_q <= 16'h1;
    end else begin
      run_q <= run_q + 16'h1;
    end
    last_q <= line_i;
  end
endmodule // dfpc_fan_model

// file: sim/dfpc_top_assertions.sv
// Port checker for the fan drive block.
// Assumes reset is held for at least two cycles.
`timescale 1ns/1ns
module dfpc_top_checker #(
  parameter integer TACH_BASE = 100
) (
  input wire       clk_sys_i,
  input wire       reset_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire       reg_wr_i,
  input wire       reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire       drive_out_a_o,
  input wire       drive_out_b_o,
  input wire       tach_tick_a_o,
  input wire       tach_tick_b_o
);
  reg [7:0]  sha_q, shb_q, shc_q;
  reg [15:0] cnt_q;
  reg [1:0]  seen_q;
  // Shadows; the tick spacing is judged only after two clean ticks
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      sha_q <= 8'h00;
      shb_q <= 8'h00;
      shc_q <= 8'h50;
      cnt_q <= 16'h0;
      seen_q <= 2'h0;
    end else begin
      cnt_q <= tach_tick_a_o ? 16'h1 : cnt_q + 16'h1;
      if (tach_tick_a_o && seen_q != 2'h2) seen_q <= seen_q + 2'h1;
      if (reg_wr_i && reg_addr_i == 8'h56) sha_q <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == 8'h57) shb_q <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == 8'h58) begin
        shc_q <= reg_wdata_i;
        seen_q <= 2'h0;
      end
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  a_static_high: assert property ($past(sha_q[0], 2) && $past(sha_q[0]) |-> drive_out_a_o)
    else $error("channel one not high while static");
  a_static_b_high: assert property ($past(shb_q[0], 2) && $past(shb_q[0]) |-> drive_out_b_o)
    else $error("channel two not high while static");
  a_zero_duty_low: assert property ($past(sha_q[6:0], 2) == 7'h0 && $past(sha_q[6:0]) == 7'h0
    |-> !drive_out_a_o)
    else $error("channel one high with zero duty");
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside read");
  a_read_drive: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 8'h56
    |-> reg_rdata_o == $past(sha_q))
    else $error("drive register readback wrong");
  a_read_ctl: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 8'h58
    |-> reg_rdata_o == $past(shc_q))
    else $error("control register readback wrong");
  a_read_unmapped: assert property ($past(reg_rd_i) && ($past(reg_addr_i) < 8'h56 ||
    $past(reg_addr_i) > 8'h58) |-> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_tach_spacing: assert property (tach_tick_a_o && seen_q == 2'h2
    |-> cnt_q == TACH_BASE << shc_q[5:4])
    else $error("tachometer tick spacing wrong");
  a_tick_pulse: assert property (tach_tick_b_o |=> !tach_tick_b_o)
    else $error("tachometer tick longer than one cycle");
endmodule // dfpc_top_checker

bind dfpc_top dfpc_top_checker #(.TACH_BASE(TACH_BASE)) i_checker (.clk_sys_i, .reset_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .drive_out_a_o,
  .drive_out_b_o, .tach_tick_a_o, .tach_tick_b_o);

// file: sim/dfpc_top_bench.sv
// Self-checking bench for the fan drive block, with line models on every fan and tachometer output.
// Assumes shortened step counts 4,3,2,1 and a tachometer base of 4 cycles.
`timescale 1ns/1ns
module dfpc_top_bench;
  reg         clk_sys_i = 1'b0;
  reg         reset_i = 1'b1;
  reg  [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
  reg         reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  wire [7:0]  reg_rdata_o;
  wire        drive_out_a_o, drive_out_b_o, tach_tick_a_o, tach_tick_b_o;
  wire [15:0] ha, la, hb, lb, ta, tb;
  integer     errors = 0, num_checks = 0, k;
  reg  [1:0]  idx;
  reg  [5:0]  d;
  reg  [15:0] s;
  always #5 clk_sys_i = ~clk_sys_i;
  dfpc_top #(.STEP_00(4), .STEP_01(3), .STEP_10(2), .STEP_11(1), .TACH_BASE(4)) i_dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .drive_out_a_o(drive_out_a_o), .drive_out_b_o(drive_out_b_o),
    .tach_tick_a_o(tach_tick_a_o), .tach_tick_b_o(tach_tick_b_o));
  dfpc_fan_model i_ma (.clk_sys_i(clk_sys_i), .line_i(drive_out_a_o), .hi_len_o(ha), .lo_len_o(la));
  dfpc_fan_model i_mb (.clk_sys_i(clk_sys_i), .line_i(drive_out_b_o), .hi_len_o(hb), .lo_len_o(lb));
  dfpc_fan_model i_ta (.clk_sys_i(clk_sys_i), .line_i(tach_tick_a_o), .hi_len_o(), .lo_len_o(ta));
  dfpc_fan_model i_tb (.clk_sys_i(clk_sys_i), .line_i(tach_tick_b_o), .hi_len_o(), .lo_len_o(tb));
  task chk(input [15:0] seen, input [15:0] exp, input string nm);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp, input string nm);
    begin
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, exp, nm);
    end
  endtask
  task print_verdict;
    begin
      if (errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    errors = errors + 1;
    print_verdict;
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd(8'h56, 8'h00, "drive one reset");
    rd(8'h57, 8'h00, "drive two reset");
    rd(8'h58, 8'h50, "clocking reset");
    wr(8'h59, 8'hff);
    rd(8'h59, 8'h00, "unmapped read");
    repeat (300) @(posedge clk_sys_i);
    #1 chk(ta + 16'h1, 16'h8, "default tach spacing");
    for (k = 0; k < 4; k = k + 1) begin
      wr(8'h58, {k[1:0], k[1:0], 4'h0});
      repeat (300) @(posedge clk_sys_i);
      #1 chk(ta + 16'h1, 16'h4 << k, "tach spacing one");
      chk(tb + 16'h1, 16'h4 << k, "tach spacing two");
    end
    // Odd steps halve with truncation, so doubling is tried on even steps only
    for (k = 0; k < 6; k = k + 1) begin
      idx = (k < 4) ? k[1:0] : {k[0], 1'b0};
      d = (k % 3 == 0) ? 6'h01 : (k % 3 == 1) ? 6'h20 : 6'h3f;
      s = (16'h4 - idx) >> k[2];
      wr(8'h58, {4'h5, k[2], k[2], idx[0], idx[0]});
      wr(8'h56, {idx[1], d, 1'b0});
      wr(8'h57, {idx[1], 6'h0 - d, 1'b0});
      repeat (800) @(posedge clk_sys_i);
      #1 chk(ha, d * s, "high run one");
      chk(la, (16'h40 - d) * s, "low run one");
      chk(hb, (16'h40 - d) * s, "high run two");
      chk(lb, d * s, "low run two");
    end
    wr(8'h56, 8'h7f);
    wr(8'h57, 8'h80);
    rd(8'h56, 8'h7f, "drive one readback");
    rd(8'h58, 8'h5c, "clocking readback");
    for (k = 0; k < 4; k = k + 1) begin
      repeat (100) @(posedge clk_sys_i);
      #1 chk(drive_out_a_o, 16'h1, "static level one");
      chk(drive_out_b_o, 16'h0, "zero duty level two");
    end
    // Static bit must override a half duty code at four sampled phases
    wr(8'h57, 8'h41);
    rd(8'h57, 8'h41, "drive two readback");
    for (k = 0; k < 4; k = k + 1) begin
      repeat (37) @(posedge clk_sys_i);
      #1 chk(drive_out_b_o, 16'h1, "static level two");
    end
    // Mid-run reset returns every register to its reset value
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd(8'h56, 8'h00, "drive one after reset");
    rd(8'h57, 8'h00, "drive two after reset");
    rd(8'h58, 8'h50, "clocking after reset");
    #1 chk(drive_out_b_o, 16'h0, "reset level two");
    print_verdict;
  end
endmodule // dfpc_top_bench
